// ==== logic/sla_pkg.sv ====
// constants and types for the secondary link activation controller
// assumes a single 200 MHz clock and utilization figures already in percent
package sla_pkg;
   localparam logic [6:0]  UP_MIN_PCT     = 7'h32;
   localparam logic [6:0]  UP_MAX_PCT     = 7'h64;
   localparam logic [6:0]  DOWN_GAP_PCT   = 7'h0a;
   localparam logic [5:0]  MIN_MINUTES    = 6'h01;
   localparam logic [5:0]  MAX_MINUTES    = 6'h3c;
   localparam logic [4:0]  SLOT_MINUTES   = 5'h1e;
   localparam logic [5:0]  SLOTS_PER_DAY  = 6'h30;
   localparam int          PRE_W          = 34;
   localparam longint      MINUTE_NS      = 64'd60_000_000_000;
   localparam longint      CLK_PERIOD_NS  = 64'd5;
   localparam longint      MINUTE_CYCLES  = MINUTE_NS / CLK_PERIOD_NS;
   localparam int          NUM_LINKS      = 2;

   typedef enum logic [1:0] {
      SLA_STANDBY = 2'b00,
      SLA_ACTIVE  = 2'b01
   } sla_state_t;
endpackage

// ==== logic/sla_top.sv ====
// secondary link activation: traffic, schedule and failure driven link control
// assumes prim_util, sec_util and configuration come from logic on clk;
// main_fail is an external pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module sla_top #(
   parameter logic [sla_pkg::PRE_W-1:0] MINUTE_CYCLES = sla_pkg::PRE_W'(sla_pkg::MINUTE_CYCLES)
) (
   input  wire logic        clk,            // 200 MHz system clock
   input  wire logic        rst_n,          // synchronous reset, active low
   input  wire logic        cond_en,        // conditional operation enabled
   input  wire logic        traffic_en,     // traffic cause enabled
   input  wire logic        sched_en,       // schedule cause enabled for secondary
   input  wire logic        fail_en,        // main link failure cause enabled
   input  wire logic        prim_sched_en,  // primary link follows its own schedule
   input  wire logic [6:0]  up_thresh,      // up threshold, percent
   input  wire logic [5:0]  up_minutes,     // up stability time, minutes
   input  wire logic        down_prog,      // down threshold programmed explicitly
   input  wire logic [6:0]  down_thresh,    // programmed down threshold, percent
   input  wire logic [5:0]  down_minutes,   // down stability time, minutes
   input  wire logic [6:0]  prim_util,      // primary utilization, percent
   input  wire logic [6:0]  sec_util,       // secondary throughput, percent of primary bw
   input  wire logic        main_fail,      // main link failure pin, asynchronous
   input  wire logic [47:0] sched_mask0,    // slot enables, primary link
   input  wire logic [47:0] sched_mask1,    // slot enables, secondary link
   input  wire logic        tod_load,       // load time of day, one-cycle pulse
   input  wire logic [5:0]  tod_slot,       // slot to load
   input  wire logic        pkt_valid,      // one outgoing packet to place, pulse
   output logic             prim_ctrl,      // primary link control signal
   output logic             sec_ctrl,       // secondary link control signal
   output logic             sec_sel,        // current packet goes to secondary
   output logic             traffic_act,    // traffic cause holds link up
   output logic [5:0]       cur_slot        // current half-hour slot
);
   localparam logic [sla_pkg::PRE_W-1:0] PRE_LAST = MINUTE_CYCLES - sla_pkg::PRE_W'(1);

   sla_pkg::sla_state_t state, next_state;
   logic                fail_m, fail_s;
   logic [sla_pkg::PRE_W-1:0] tod_pre, next_tod_pre, up_pre, next_up_pre, dn_pre, next_dn_pre;
   logic [4:0]          tod_min, next_tod_min;
   logic [5:0]          next_cur_slot, up_cnt, next_up_cnt, dn_cnt, next_dn_cnt;
   logic                next_traffic_act, next_prim_ctrl, next_sec_ctrl, next_sec_sel;
   logic [6:0]          eff_up, eff_down;
   logic [5:0]          eff_up_min, eff_dn_min;
   logic [7:0]          comb_pct;
   logic                up_hot, dn_cold, sched_on, fail_on, want;
   logic [47:0]         masks [sla_pkg::NUM_LINKS];
   logic [sla_pkg::NUM_LINKS-1:0] slot_on;

   // pin crossing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_m <= 1'b0;
         fail_s <= 1'b0;
      end else begin
         fail_m <= main_fail;
         fail_s <= fail_m;
      end
   end

   // effective settings
   always_comb begin
      if (up_thresh < sla_pkg::UP_MIN_PCT)
         eff_up = sla_pkg::UP_MIN_PCT;
      else if (up_thresh > sla_pkg::UP_MAX_PCT)
         eff_up = sla_pkg::UP_MAX_PCT;
      else
         eff_up = up_thresh;
      eff_down = down_prog ? down_thresh : eff_up - sla_pkg::DOWN_GAP_PCT;
      if (up_minutes < sla_pkg::MIN_MINUTES)
         eff_up_min = sla_pkg::MIN_MINUTES;
      else if (up_minutes > sla_pkg::MAX_MINUTES)
         eff_up_min = sla_pkg::MAX_MINUTES;
      else
         eff_up_min = up_minutes;
      if (down_minutes < sla_pkg::MIN_MINUTES)
         eff_dn_min = sla_pkg::MIN_MINUTES;
      else if (down_minutes > sla_pkg::MAX_MINUTES)
         eff_dn_min = sla_pkg::MAX_MINUTES;
      else
         eff_dn_min = down_minutes;
      comb_pct = {1'b0, prim_util} + {1'b0, sec_util};
      up_hot   = prim_util > eff_up;
      dn_cold  = comb_pct < {1'b0, eff_down};
   end

   // per-link schedule lookup
   assign masks[0] = sched_mask0;
   assign masks[1] = sched_mask1;
   generate
      for (genvar g = 0; g < sla_pkg::NUM_LINKS; g++) begin : g_link
         assign slot_on[g] = masks[g][cur_slot];
      end
   endgenerate

   // time of day
   always_comb begin
      next_tod_pre  = tod_pre;
      next_tod_min  = tod_min;
      next_cur_slot = cur_slot;
      if (tod_load) begin
         next_tod_pre  = '0;
         next_tod_min  = '0;
         next_cur_slot = (tod_slot < sla_pkg::SLOTS_PER_DAY) ? tod_slot : 6'h00;
      end else if (tod_pre == PRE_LAST) begin
         next_tod_pre = '0;
         if (tod_min == sla_pkg::SLOT_MINUTES - 5'h01) begin
            next_tod_min = '0;
            if (cur_slot == sla_pkg::SLOTS_PER_DAY - 6'h01)
               next_cur_slot = '0;
            else
               next_cur_slot = cur_slot + 6'h01;
         end else begin
            next_tod_min = tod_min + 5'h01;
         end
      end else begin
         next_tod_pre = tod_pre + sla_pkg::PRE_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tod_pre  <= '0;
         tod_min  <= '0;
         cur_slot <= '0;
      end else begin
         tod_pre  <= next_tod_pre;
         tod_min  <= next_tod_min;
         cur_slot <= next_cur_slot;
      end
   end

   // traffic stability timers; each has its own prescaler so the first minute is whole
   always_comb begin
      next_up_pre      = up_pre;
      next_up_cnt      = up_cnt;
      next_dn_pre      = dn_pre;
      next_dn_cnt      = dn_cnt;
      next_traffic_act = traffic_act;
      if (!cond_en || !traffic_en) begin
         next_up_pre      = '0;
         next_up_cnt      = '0;
         next_dn_pre      = '0;
         next_dn_cnt      = '0;
         next_traffic_act = 1'b0;
      end else if (!traffic_act) begin
         next_dn_pre = '0;
         next_dn_cnt = '0;
         if (!up_hot) begin
            next_up_pre = '0;
            next_up_cnt = '0;
         end else if (up_pre == PRE_LAST) begin
            next_up_pre = '0;
            if (up_cnt + 6'h01 >= eff_up_min) begin
               next_up_cnt      = '0;
               next_traffic_act = 1'b1;
            end else begin
               next_up_cnt = up_cnt + 6'h01;
            end
         end else begin
            next_up_pre = up_pre + sla_pkg::PRE_W'(1);
         end
      end else begin
         next_up_pre = '0;
         next_up_cnt = '0;
         if (!dn_cold) begin
            next_dn_pre = '0;
            next_dn_cnt = '0;
         end else if (dn_pre == PRE_LAST) begin
            next_dn_pre = '0;
            if (dn_cnt + 6'h01 >= eff_dn_min) begin
               next_dn_cnt      = '0;
               next_traffic_act = 1'b0;
            end else begin
               next_dn_cnt = dn_cnt + 6'h01;
            end
         end else begin
            next_dn_pre = dn_pre + sla_pkg::PRE_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         up_pre      <= '0;
         up_cnt      <= '0;
         dn_pre      <= '0;
         dn_cnt      <= '0;
         traffic_act <= 1'b0;
      end else begin
         up_pre      <= next_up_pre;
         up_cnt      <= next_up_cnt;
         dn_pre      <= next_dn_pre;
         dn_cnt      <= next_dn_cnt;
         traffic_act <= next_traffic_act;
      end
   end

   // link control and load sharing
   always_comb begin
      sched_on = sched_en & slot_on[1];
      fail_on  = fail_en & fail_s;
      want     = sched_on | fail_on | traffic_act;
      next_state = state;
      case (state)
         sla_pkg::SLA_STANDBY: begin
            if (!cond_en || want)
               next_state = sla_pkg::SLA_ACTIVE;
         end
         sla_pkg::SLA_ACTIVE: begin
            if (cond_en && !want)
               next_state = sla_pkg::SLA_STANDBY;
         end
         default: next_state = sla_pkg::SLA_STANDBY;
      endcase
      // the modem dials on the rising edge of this level and hangs up on the fall
      next_sec_ctrl  = (next_state == sla_pkg::SLA_ACTIVE);
      next_prim_ctrl = prim_sched_en ? slot_on[0] : 1'b1;
      // secondary down: all to primary; secondary up: a failed main link gets nothing, otherwise alternate per packet
      if (!next_sec_ctrl)
         next_sec_sel = 1'b0;
      else if (fail_s)
         next_sec_sel = 1'b1;
      else if (pkt_valid)
         next_sec_sel = ~sec_sel;
      else
         next_sec_sel = sec_sel;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= sla_pkg::SLA_STANDBY;
         sec_ctrl  <= 1'b0;
         prim_ctrl <= 1'b0;
         sec_sel   <= 1'b0;
      end else begin
         state     <= next_state;
         sec_ctrl  <= next_sec_ctrl;
         prim_ctrl <= next_prim_ctrl;
         sec_sel   <= next_sec_sel;
      end
   end

   property p_up_range;
      @(posedge clk) disable iff (!rst_n)
      eff_up >= sla_pkg::UP_MIN_PCT && eff_up <= sla_pkg::UP_MAX_PCT;
   endproperty
   a_up_range: assert property (p_up_range) else $error("up threshold out of range");

   property p_up_start;
      @(posedge clk) disable iff (!rst_n)
      $rose(traffic_act) |-> $past(up_hot) && ($past(up_cnt) + 6'h01 >= $past(eff_up_min));
   endproperty
   a_up_start: assert property (p_up_start) else $error("traffic up before time");

   // checked from the raw setting, so a broken default path cannot agree with itself
   property p_down_default;
      @(posedge clk) disable iff (!rst_n)
      (!down_prog && up_thresh >= sla_pkg::UP_MIN_PCT && up_thresh <= sla_pkg::UP_MAX_PCT)
         |-> eff_down == up_thresh - sla_pkg::DOWN_GAP_PCT;
   endproperty
   a_down_default: assert property (p_down_default) else $error("bad default down");

   property p_down_comb;
      @(posedge clk) disable iff (!rst_n)
      (cond_en && traffic_en && traffic_act && comb_pct >= {1'b0, eff_down}) |=> dn_cnt == 6'h00;
   endproperty
   a_down_comb: assert property (p_down_comb) else $error("down timer ran above threshold");

   property p_down_stop;
      @(posedge clk) disable iff (!rst_n)
      $fell(traffic_act) && $past(cond_en) && $past(traffic_en)
         |-> $past(dn_cold) && ($past(dn_cnt) + 6'h01 >= $past(eff_dn_min));
   endproperty
   a_down_stop: assert property (p_down_stop) else $error("traffic down before time");

   property p_raise;
      @(posedge clk) disable iff (!rst_n)
      (state == sla_pkg::SLA_STANDBY && cond_en && (sched_on || fail_on))
         |=> sec_ctrl && state == sla_pkg::SLA_ACTIVE;
   endproperty
   a_raise: assert property (p_raise) else $error("control not raised");

   property p_lower;
      @(posedge clk) disable iff (!rst_n)
      (state == sla_pkg::SLA_ACTIVE && cond_en && !want) |=> !sec_ctrl && !sec_sel;
   endproperty
   a_lower: assert property (p_lower) else $error("control not lowered");

   property p_uncond;
      @(posedge clk) disable iff (!rst_n)
      !cond_en [*2] |=> sec_ctrl && !traffic_act;
   endproperty
   a_uncond: assert property (p_uncond) else $error("unconditional link not up");

   property p_prim_sched;
      @(posedge clk) disable iff (!rst_n)
      prim_sched_en |=> prim_ctrl == $past(slot_on[0]);
   endproperty
   a_prim_sched: assert property (p_prim_sched) else $error("primary schedule ignored");

   property p_share;
      @(posedge clk) disable iff (!rst_n)
      (sec_ctrl && next_sec_ctrl && !fail_s && pkt_valid) |=> sec_sel != $past(sec_sel);
   endproperty
   a_share: assert property (p_share) else $error("no alternation");

   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      (!traffic_act && !up_hot) |=> up_cnt == 6'h00 && up_pre == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("up timer not restarted");
endmodule
`default_nettype wire

// ==== verification/sla_modem.sv ====
// behavioural modem or terminal adapter on the secondary link
// assumes ctrl is the block's secondary control level, sampled on clk
`timescale 1ns/1ps
`default_nettype none
module sla_modem (
   input  wire logic clk,      // system clock
   input  wire logic ctrl,     // secondary control level from the block
   output int        dials,    // calls placed so far
   output int        hangs,    // calls cleared so far
   output logic      call_up   // call currently connected
);
   logic last = 1'b0;

   initial begin
      dials = 0;
      hangs = 0;
      call_up = 1'b0;
   end

   // dial on the rising control edge, clear on the falling one
   always @(posedge clk) begin
      if (ctrl === 1'b1 && last === 1'b0) begin
         dials <= dials + 1;
         call_up <= 1'b1;
      end
      if (ctrl === 1'b0 && last === 1'b1) begin
         hangs <= hangs + 1;
         call_up <= 1'b0;
      end
      last <= ctrl;
   end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the secondary link activation controller
// assumes a short minute (MC cycles) so stability timers and slots fit the run
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int MC = 20;
   logic clk = 1'b0, rst_n = 1'b0, cond_en = 1'b1, traffic_en = 1'b1, sched_en = 1'b0;
   logic fail_en = 1'b0, prim_sched_en = 1'b0, down_prog = 1'b0, main_fail = 1'b0;
   logic tod_load = 1'b0, pkt_valid = 1'b0;
   logic [6:0] up_thresh = 7'h3c, down_thresh = 7'h00, prim_util = 7'h00, sec_util = 7'h00;
   logic [5:0] up_minutes = 6'h02, down_minutes = 6'h01, tod_slot = 6'h00, cur_slot;
   logic [47:0] sched_mask0 = 48'h0, sched_mask1 = 48'h0;
   logic prim_ctrl, sec_ctrl, sec_sel, traffic_act, call_up;
   int num_errors = 0, checked = 0, dials, hangs;

   always #2.5 clk = ~clk;

   sla_top #(.MINUTE_CYCLES(sla_pkg::PRE_W'(MC))) sla_top_i (
      .clk(clk), .rst_n(rst_n), .cond_en(cond_en), .traffic_en(traffic_en),
      .sched_en(sched_en), .fail_en(fail_en), .prim_sched_en(prim_sched_en),
      .up_thresh(up_thresh), .up_minutes(up_minutes), .down_prog(down_prog),
      .down_thresh(down_thresh), .down_minutes(down_minutes), .prim_util(prim_util),
      .sec_util(sec_util), .main_fail(main_fail), .sched_mask0(sched_mask0),
      .sched_mask1(sched_mask1), .tod_load(tod_load), .tod_slot(tod_slot),
      .pkt_valid(pkt_valid), .prim_ctrl(prim_ctrl), .sec_ctrl(sec_ctrl),
      .sec_sel(sec_sel), .traffic_act(traffic_act), .cur_slot(cur_slot));

   sla_modem sla_modem_i (.clk(clk), .ctrl(sec_ctrl), .dials(dials), .hangs(hangs),
      .call_up(call_up));

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // one-cycle packet; sec_sel settles on the edge that takes it
   task automatic pkt;
      pkt_valid = 1'b1;
      cyc(1);
      pkt_valid = 1'b0;
      cyc(1);
   endtask

   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic t_reset;
      cyc(12);
      chk("sec_ctrl in reset", 8'h0, {7'h0, sec_ctrl});
      chk("slot in reset", 8'h0, {2'h0, cur_slot});
      rst_n = 1'b1;
      cyc(3);
      chk("sec_ctrl idle", 8'h0, {7'h0, sec_ctrl});
      chk("prim_ctrl unscheduled", 8'h1, {7'h0, prim_ctrl});
   endtask

   task automatic t_uncond;
      logic s0;
      cond_en = 1'b0;
      cyc(3);
      chk("sec_ctrl unconditional", 8'h1, {7'h0, sec_ctrl});
      chk("dials", 8'h1, dials[7:0]);
      chk("call_up dialled", 8'h1, {7'h0, call_up});
      s0 = sec_sel;
      pkt();
      chk("sec_sel toggle", {7'h0, ~s0}, {7'h0, sec_sel});
      pkt();
      chk("sec_sel toggle back", {7'h0, s0}, {7'h0, sec_sel});
      cond_en = 1'b1;
      cyc(3);
      chk("sec_ctrl standby", 8'h0, {7'h0, sec_ctrl});
      chk("hangs", 8'h1, hangs[7:0]);
      chk("call_up cleared", 8'h0, {7'h0, call_up});
   endtask

   // 60 percent up, 2 minutes; a dip to the threshold restarts the timer
   task automatic t_traffic;
      prim_util = 7'h3d;
      cyc(30);
      prim_util = 7'h3c;
      cyc(1);
      prim_util = 7'h3d;
      cyc(2 * MC - 3);
      chk("traffic_act early", 8'h0, {7'h0, traffic_act});
      cyc(6);
      chk("traffic_act", 8'h1, {7'h0, traffic_act});
      chk("sec_ctrl traffic", 8'h1, {7'h0, sec_ctrl});
      // primary alone under 50 but combined 51: must stay up
      prim_util = 7'h2d;
      sec_util = 7'h06;
      cyc(3 * MC);
      chk("sec_ctrl combined", 8'h1, {7'h0, sec_ctrl});
      sec_util = 7'h04;
      cyc(MC - 3);
      chk("sec_ctrl down early", 8'h1, {7'h0, sec_ctrl});
      cyc(6);
      chk("sec_ctrl down", 8'h0, {7'h0, sec_ctrl});
      chk("hangs traffic", 8'h2, hangs[7:0]);
   endtask

   // threshold 127 acts as 100, 30 is lifted to 50; minutes 0 act as 1
   task automatic t_clamp;
      up_thresh = 7'h7f;
      up_minutes = 6'h00;
      prim_util = 7'h65;
      sec_util = 7'h00;
      cyc(MC + 4);
      chk("traffic_act clamp high", 8'h1, {7'h0, traffic_act});
      prim_util = 7'h00;
      cyc(2 * MC);
      chk("traffic_act clamp high off", 8'h0, {7'h0, traffic_act});
      up_thresh = 7'h1e;
      prim_util = 7'h2d;
      cyc(3 * MC);
      chk("traffic_act clamped", 8'h0, {7'h0, traffic_act});
      prim_util = 7'h33;
      cyc(MC + 4);
      chk("traffic_act min", 8'h1, {7'h0, traffic_act});
      // programmed 30 keeps combined 35 up where the default 40 would drop it
      down_prog = 1'b1;
      down_thresh = 7'h1e;
      prim_util = 7'h23;
      cyc(2 * MC);
      chk("sec_ctrl programmed down", 8'h1, {7'h0, sec_ctrl});
      prim_util = 7'h00;
      cyc(2 * MC);
      chk("sec_ctrl clamp down", 8'h0, {7'h0, sec_ctrl});
      down_prog = 1'b0;
   endtask

   task automatic t_sched;
      traffic_en = 1'b0;
      sched_en = 1'b1;
      prim_sched_en = 1'b1;
      sched_mask0 = 48'h10;
      sched_mask1 = 48'h20;
      tod_slot = 6'h04;
      tod_load = 1'b1;
      cyc(1);
      tod_load = 1'b0;
      cyc(3);
      chk("slot loaded", 8'h4, {2'h0, cur_slot});
      chk("sec_ctrl off slot", 8'h0, {7'h0, sec_ctrl});
      chk("prim_ctrl slot4", 8'h1, {7'h0, prim_ctrl});
      cyc(30 * MC - 10);
      chk("slot held", 8'h4, {2'h0, cur_slot});
      cyc(10);
      chk("slot next", 8'h5, {2'h0, cur_slot});
      chk("sec_ctrl slot5", 8'h1, {7'h0, sec_ctrl});
      chk("prim_ctrl slot5", 8'h0, {7'h0, prim_ctrl});
      sched_en = 1'b0;
      cyc(3);
      chk("sec_ctrl sched off", 8'h0, {7'h0, sec_ctrl});
      tod_slot = 6'h3f;
      tod_load = 1'b1;
      cyc(1);
      tod_load = 1'b0;
      cyc(1);
      chk("slot out of range", 8'h0, {2'h0, cur_slot});
   endtask

   task automatic t_fail;
      fail_en = 1'b1;
      main_fail = 1'b1;
      cyc(5);
      chk("sec_ctrl fail", 8'h1, {7'h0, sec_ctrl});
      pkt();
      chk("sec_sel fail", 8'h1, {7'h0, sec_sel});
      pkt();
      chk("sec_sel fail again", 8'h1, {7'h0, sec_sel});
      main_fail = 1'b0;
      cyc(5);
      chk("sec_ctrl fail over", 8'h0, {7'h0, sec_ctrl});
   endtask

   initial begin
      #(5 * 6000);
      num_errors++;
      $display("BAD watchdog expected done seen hang");
      conclude();
   end

   initial begin
      t_reset();
      t_uncond();
      t_traffic();
      t_clamp();
      t_sched();
      t_fail();
      conclude();
   end
endmodule
`default_nettype wire
